// File: rtl/acp_port.sv
// Notes on behaviour
// - four command inputs, three alarm outputs
// - command inputs and alarm outputs active low
// - reject under 40 ms, accept over 60 ms
// - qualified assertion runs the input's action
// - action none ignores the input
// - reset program time counter
// - request positioning receiver reset
// - jam sync drop-frame time code now
// - time update only when source internal
// - recall preset selected for that input
// - output is OR of selected events
// - level alarms follow their condition
// - alarm time matches hours minutes seconds
// - alarm time asserts exactly one second
// - leader to passive gives 20 ms pulse
// - nine indicator events selectable
// - delayed alarm needs continuous presence
// - delays only on five alarms
`timescale 1ns/100ps
`include "acp_params.svh"

module acp_port
   import acp_pkg::*;
#(
   parameter int unsigned MS_CYC = `ACP_MS_NS / `ACP_CLK_PERIOD_NS
)
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        reset_n,
   // apb slave
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // command and alarm pins
   input  wire logic [3:0]  cmd_n_pin,
   output logic      [2:0]  alarm_n,
   // system state
   input  wire acp_lvl_s    lvl_evt,
   input  wire logic [1:0]  grandmaster_role,
   input  wire logic [4:0]  prog_hours,
   input  wire logic [5:0]  prog_minutes,
   input  wire logic [5:0]  prog_seconds,
   input  wire logic        tod_internal,
   // action requests
   output acp_act_s         act_req,
   output logic      [7:0]  preset_sel
);

   localparam logic [5:0]  FILT_TICKS  = 6'(`ACP_FILT_MS);
   localparam logic [9:0]  HOLD_TICKS  = 10'(`ACP_ALARM_HOLD_MS);
   localparam logic [9:0]  PULSE_TICKS = 10'(`ACP_PTP_PULSE_MS);
   localparam logic [15:0] MS_LAST     = 16'(MS_CYC - 1);
   localparam int          N_DLY       = 5;

   // reg index from byte address
   function automatic logic [5:0] reg_idx(input logic [7:0] a);
      reg_idx = a[7:2];
   endfunction : reg_idx

   function automatic logic [2:0] act_field(input logic [31:0] r, input int i);
      act_field = r[i*`ACP_ACT_STRIDE +: `ACP_ACT_W];
   endfunction : act_field

   logic [31:0]          action_q;
   logic [31:0]          preset_q;
   logic [`ACP_SEL_W-1:0] out_sel_q [3];
   logic [`ACP_DLY_W-1:0] dly_q [N_DLY];
   logic [31:0]          alarm_time_q;

   logic [15:0]          ms_cnt_q;
   logic                 tick_q;

   logic [3:0]           s1_q, s2_q, s3_q, lvl_q;
   logic [5:0]           fcnt_q [4];
   logic [3:0]           qual_q;
   logic [3:0]           fire_q;

   logic [`ACP_DLY_W-1:0] acnt_q [N_DLY];
   logic [N_DLY-1:0]     dly_ok;
   logic [5:0]           lvl_ok;

   logic                 match_q;
   logic [1:0]           role_q;
   logic [2:0]           pend_q;
   logic [9:0]           tmr_q [3];
   logic [2:0]           start;
   logic [`ACP_SEL_W-1:0] evt_vec;

   logic                 wr_en;
   logic                 setup;
   logic [31:0]          rd_d;
   logic                 err_d;
   logic [5:0]           idx;

   // apb decode
   assign setup = psel & ~penable;
   assign wr_en = psel & penable & pready & pwrite;
   assign idx   = reg_idx(paddr);

   always_comb
   begin
      rd_d  = 32'h0000_0000;
      err_d = 1'b0;
      if (idx == reg_idx(`ACP_OFS_ACTION))
         rd_d = action_q;
      else if (idx == reg_idx(`ACP_OFS_PRESET))
         rd_d = preset_q;
      else if (idx >= reg_idx(`ACP_OFS_OUT_SEL0) && idx < reg_idx(`ACP_OFS_DELAY0))
         rd_d = {23'h0, out_sel_q[2'(idx - reg_idx(`ACP_OFS_OUT_SEL0))]};
      else if (idx >= reg_idx(`ACP_OFS_DELAY0) && idx < reg_idx(`ACP_OFS_ALARM_TIME))
         rd_d = {16'h0000, dly_q[3'(idx - reg_idx(`ACP_OFS_DELAY0))]};
      else if (idx == reg_idx(`ACP_OFS_ALARM_TIME))
         rd_d = alarm_time_q;
      else if (idx == reg_idx(`ACP_OFS_STATUS))
         rd_d = {10'h000, ~alarm_n, 2'h0, evt_vec, lvl_q, qual_q};
      else
         err_d = 1'b1;
   end

   // one access cycle: answer prepared at setup
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end
      else
      begin
         pready  <= setup;
         pslverr <= setup & err_d;
         prdata  <= (setup && !pwrite) ? rd_d : 32'h0000_0000;
      end
   end

   // config registers, status writes ignored
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         action_q     <= `ACP_RST_ACTION;
         preset_q     <= `ACP_RST_PRESET;
         alarm_time_q <= `ACP_RST_ALARM_TIME;
         for (int j = 0; j < 3; j++)
            out_sel_q[j] <= `ACP_RST_SEL;
         for (int k = 0; k < N_DLY; k++)
            dly_q[k] <= `ACP_RST_DELAY;
      end
      else if (wr_en)
      begin
         if (idx == reg_idx(`ACP_OFS_ACTION))
            action_q <= pwdata & 32'h7777;
         if (idx == reg_idx(`ACP_OFS_PRESET))
            preset_q <= pwdata;
         if (idx == reg_idx(`ACP_OFS_ALARM_TIME))
            alarm_time_q <= pwdata & 32'h001f_3f3f;
         for (int j = 0; j < 3; j++)
            if (idx == reg_idx(`ACP_OFS_OUT_SEL0) + 6'(j))
               out_sel_q[j] <= pwdata[`ACP_SEL_W-1:0];
         for (int k = 0; k < N_DLY; k++)
            if (idx == reg_idx(`ACP_OFS_DELAY0) + 6'(k))
               dly_q[k] <= pwdata[`ACP_DLY_W-1:0];
      end
   end

   // millisecond tick
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ms_cnt_q <= 16'h0000;
         tick_q   <= 1'b0;
      end
      else
      begin
         tick_q   <= (ms_cnt_q == MS_LAST);
         ms_cnt_q <= (ms_cnt_q == MS_LAST) ? 16'h0000 : ms_cnt_q + 16'h0001;
      end
   end

   // pin synchroniser, change taken when stages two and three agree
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         s1_q  <= 4'hf;
         s2_q  <= 4'hf;
         s3_q  <= 4'hf;
         lvl_q <= 4'hf;
      end
      else
      begin
         s1_q <= cmd_n_pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
         for (int i = 0; i < 4; i++)
            if (s2_q[i] == s3_q[i])
               lvl_q[i] <= s3_q[i];
      end
   end

   // stable-low filter, one fire per assertion
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         qual_q <= 4'h0;
         fire_q <= 4'h0;
         for (int i = 0; i < 4; i++)
            fcnt_q[i] <= 6'h00;
      end
      else
      begin
         for (int i = 0; i < 4; i++)
         begin
            fire_q[i] <= 1'b0;
            if (lvl_q[i])
            begin
               fcnt_q[i] <= 6'h00;
               qual_q[i] <= 1'b0;
            end
            else if (tick_q && !qual_q[i])
            begin
               if (fcnt_q[i] == FILT_TICKS - 6'h01)
               begin
                  qual_q[i] <= 1'b1;
                  fire_q[i] <= 1'b1;
               end
               fcnt_q[i] <= fcnt_q[i] + 6'h01;
            end
         end
      end
   end

   // run the configured action of each fired input
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         act_req    <= '0;
         preset_sel <= 8'h00;
      end
      else
      begin
         act_req <= '0;
         for (int i = 0; i < 4; i++)
            if (fire_q[i])
               case (act_field(action_q, i))
                  3'(acp_act_prog_reset):
                     act_req.prog_reset <= 1'b1;
                  3'(acp_act_reacquire):
                     act_req.reacquire <= 1'b1;
                  3'(acp_act_jam_sync):
                     act_req.jam_sync <= 1'b1;
                  3'(acp_act_ntp_update):
                     act_req.ntp_update <= tod_internal;
                  3'(acp_act_recall_preset):
                  begin
                     act_req.recall_preset <= 1'b1;
                     preset_sel <= preset_q[i*`ACP_PRESET_W +: `ACP_PRESET_W];
                  end
                  default:
                     ;
               endcase
      end
   end

   // qualifying delay on hw, lock err/warn, time err/warn
   function automatic logic dly_cond(input acp_lvl_s e, input int k);
      case (k)
         0:       dly_cond = e.hw_fault;
         1:       dly_cond = e.lock_err;
         2:       dly_cond = e.lock_warn;
         3:       dly_cond = e.time_err;
         default: dly_cond = e.time_warn;
      endcase
   endfunction : dly_cond

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         for (int k = 0; k < N_DLY; k++)
            acnt_q[k] <= 16'h0000;
      else
         for (int k = 0; k < N_DLY; k++)
            if (!dly_cond(lvl_evt, k))
               acnt_q[k] <= 16'h0000;
            else if (tick_q && acnt_q[k] != 16'hffff)
               acnt_q[k] <= acnt_q[k] + 16'h0001;
   end

   always_comb
   begin
      for (int k = 0; k < N_DLY; k++)
         dly_ok[k] = dly_cond(lvl_evt, k) && (acnt_q[k] >= dly_q[k]);
   end

   // level events, power supply fault undelayed
   assign lvl_ok = {dly_ok[4], dly_ok[3], dly_ok[2], dly_ok[1],
                    lvl_evt.power_supply_fault_event, dly_ok[0]};

   // program time equals alarm time
   function automatic logic time_hit(input logic [31:0] t, input logic [4:0] h,
                                     input logic [5:0] m, input logic [5:0] s);
      time_hit = (h == t[`ACP_HOUR_LSB +: 5]) && (m == t[`ACP_MIN_LSB +: 6]) &&
                 (s == t[`ACP_SEC_LSB +: 6]);
   endfunction : time_hit

   // event edges: alarm-time match, leader lost
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         match_q <= 1'b0;
         role_q  <= 2'b00;
      end
      else
      begin
         match_q <= time_hit(alarm_time_q, prog_hours, prog_minutes, prog_seconds);
         role_q  <= grandmaster_role;
      end
   end

   assign start[0] = time_hit(alarm_time_q, prog_hours, prog_minutes, prog_seconds)
                     && !match_q;
   assign start[1] = role_q[0] & ~grandmaster_role[0];
   assign start[2] = role_q[1] & ~grandmaster_role[1];

   // fixed-length timers start on a tick so the length is exact
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         pend_q <= 3'h0;
         for (int t = 0; t < 3; t++)
            tmr_q[t] <= 10'h000;
      end
      else
         for (int t = 0; t < 3; t++)
         begin
            if (tick_q && (pend_q[t] || start[t]))
            begin
               tmr_q[t]  <= (t == 0) ? HOLD_TICKS : PULSE_TICKS;
               pend_q[t] <= 1'b0;
            end
            else
            begin
               if (start[t])
                  pend_q[t] <= 1'b1;
               if (tick_q && tmr_q[t] != 10'h000)
                  tmr_q[t] <= tmr_q[t] - 10'h001;
            end
         end
   end

   assign evt_vec = {tmr_q[2] != 10'h000, tmr_q[1] != 10'h000,
                     tmr_q[0] != 10'h000, lvl_ok};

   // outputs driven low while any selected event is true
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         alarm_n <= 3'h7;
      else
         for (int j = 0; j < 3; j++)
            alarm_n[j] <= ~|(evt_vec & out_sel_q[j]);
   end

endmodule : acp_port

// File: inc/acp_params.svh
`ifndef ACP_PARAMS_SVH
`define ACP_PARAMS_SVH

// timing
`define ACP_CLK_PERIOD_NS   25
`define ACP_MS_NS           1000000
`define ACP_FILT_MIN_MS     40
`define ACP_FILT_MAX_MS     60
`define ACP_FILT_MS         50
`define ACP_ALARM_HOLD_MS   1000
`define ACP_PTP_PULSE_MS    20

// register byte offsets
`define ACP_OFS_ACTION      8'h00
`define ACP_OFS_PRESET      8'h04
`define ACP_OFS_OUT_SEL0    8'h08
`define ACP_OFS_DELAY0      8'h14
`define ACP_OFS_ALARM_TIME  8'h28
`define ACP_OFS_STATUS      8'h2c

// field layout
`define ACP_ACT_W           3
`define ACP_ACT_STRIDE      4
`define ACP_PRESET_W        8
`define ACP_SEL_W           9
`define ACP_DLY_W           16
`define ACP_SEC_LSB         0
`define ACP_MIN_LSB         8
`define ACP_HOUR_LSB        16

// reset values
`define ACP_RST_ACTION      32'h0000_0000
`define ACP_RST_PRESET      32'h0000_0000
`define ACP_RST_SEL         9'h000
`define ACP_RST_DELAY       16'h0000
`define ACP_RST_ALARM_TIME  32'h0000_0000

`endif

// File: inc/acp_pkg.sv
package acp_pkg;

   typedef enum logic [2:0] {
      acp_act_none,
      acp_act_prog_reset,
      acp_act_reacquire,
      acp_act_jam_sync,
      acp_act_ntp_update,
      acp_act_recall_preset
   } acp_action_e;

   // level alarms, each mirrors its status indicator
   typedef struct packed {
      logic time_warn;
      logic time_err;
      logic lock_warn;
      logic lock_err;
      logic power_supply_fault_event;
      logic hw_fault;
   } acp_lvl_s;

   // one-cycle action requests to the owning subsystems
   typedef struct packed {
      logic recall_preset;
      logic ntp_update;
      logic jam_sync;
      logic reacquire;
      logic prog_reset;
   } acp_act_s;

endpackage : acp_pkg

// File: bench/acp_port_asserts.sv
`timescale 1ns/100ps
module acp_port_asserts
   import acp_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        reset_n,
   // apb
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr,
   // pins and requests
   input  wire logic [3:0]  cmd_n_pin,
   input  wire logic [2:0]  alarm_n,
   input  wire logic        tod_internal,
   input  wire acp_act_s    act_req,
   input  wire logic [7:0]  preset_sel
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   a_reset_idle: assert property ($rose(reset_n) |-> alarm_n == 3'h7 && act_req == 5'h00)
      else $error("outputs not idle after reset");
   a_cmd_needs_low: assert property (act_req != 5'h00 |-> $past(cmd_n_pin, 8) != 4'hf)
      else $error("action without a low command pin");
   a_single_fire: assert property (act_req.prog_reset |=> !act_req.prog_reset)
      else $error("action request longer than one cycle");
   a_ntp_gate: assert property (act_req.ntp_update |-> $past(tod_internal))
      else $error("time update while source not internal");
   a_preset_load: assert property ($changed(preset_sel) |-> act_req.recall_preset)
      else $error("preset index changed without recall");
   a_pready_access: assert property (psel && !penable |=> pready)
      else $error("no ready in access cycle");
   a_pready_cause: assert property (pready |-> $past(psel && !penable))
      else $error("ready without setup");
   a_slverr_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside access");

   cover property (act_req.recall_preset);
   cover property (pslverr);
   cover property ($fell(alarm_n[1]));
endmodule : acp_port_asserts

bind acp_port acp_port_asserts acp_port_asserts_i (
   .clk          (clk),
   .reset_n      (reset_n),
   .psel         (psel),
   .penable      (penable),
   .prdata       (prdata),
   .pready       (pready),
   .pslverr      (pslverr),
   .cmd_n_pin    (cmd_n_pin),
   .alarm_n      (alarm_n),
   .tod_internal (tod_internal),
   .act_req      (act_req),
   .preset_sel   (preset_sel)
);

// File: bench/acp_contacts.sv
`timescale 1ns/100ps
module acp_contacts
(
   // clock
   input  wire logic        clk,
   // changeover unit watches alarms
   input  wire logic [2:0]  alarm_n,
   output logic      [31:0] low_len [3],
   // contact closures, pulled up when open
   output logic      [3:0]  cmd_n
);
   logic [31:0] run [3] = '{default: 32'h0};

   initial cmd_n = 4'hf;
   initial low_len = '{default: 32'h0};

   task automatic press(input int i, input int cyc);
      cmd_n[i] <= 1'b0;
      repeat (cyc) @(posedge clk);
      cmd_n[i] <= 1'b1;
      @(posedge clk);
   endtask : press

   // width of the last low on each alarm
   always @(posedge clk)
      for (int k = 0; k < 3; k++)
         if (alarm_n[k] === 1'b0)
            run[k] <= run[k] + 1;
         else if (run[k] != 0)
         begin
            low_len[k] <= run[k];
            run[k] <= 0;
         end
endmodule : acp_contacts

// File: bench/tb_acp_port.sv
`timescale 1ns/100ps
module tb_acp_port
   import acp_pkg::*;
;
   localparam int MS = 4;
   logic        clk = 1'b0;
   logic        reset_n = 1'b0;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        pready, pslverr, err;
   logic        tod_internal = 1'b1;
   logic [3:0]  cmd_n_pin;
   logic [2:0]  alarm_n;
   acp_lvl_s    lvl_evt = 6'h00;
   logic [1:0]  grandmaster_role = 2'h0;
   logic [4:0]  prog_hours = 5'h00;
   // off the reset alarm time, so no one-second pulse starts at reset
   logic [5:0]  prog_minutes = 6'h00, prog_seconds = 6'h01;
   acp_act_s    act_req;
   logic [7:0]  preset_sel;
   logic [31:0] low_len [3];
   int          errors = 0, comparisons = 0;
   int          hits [5] = '{default: 0};

   acp_port #(.MS_CYC(MS)) acp_port_i (
      .clk              (clk),
      .reset_n          (reset_n),
      .paddr            (paddr),
      .psel             (psel),
      .penable          (penable),
      .pwrite           (pwrite),
      .pwdata           (pwdata),
      .prdata           (prdata),
      .pready           (pready),
      .pslverr          (pslverr),
      .cmd_n_pin        (cmd_n_pin),
      .alarm_n          (alarm_n),
      .lvl_evt          (lvl_evt),
      .grandmaster_role (grandmaster_role),
      .prog_hours       (prog_hours),
      .prog_minutes     (prog_minutes),
      .prog_seconds     (prog_seconds),
      .tod_internal     (tod_internal),
      .act_req          (act_req),
      .preset_sel       (preset_sel)
   );
   acp_contacts acp_contacts_i (.clk(clk), .alarm_n(alarm_n), .low_len(low_len),
                                .cmd_n(cmd_n_pin));

   always #12.5 clk = ~clk;

   always @(posedge clk)
      for (int b = 0; b < 5; b++)
         if (act_req[b] === 1'b1)
            hits[b] <= hits[b] + 1;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      chk(32'(n < 20), 32'h1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb

   task automatic t_regs();
      chk(32'(alarm_n), 32'h7);
      chk(32'(preset_sel), 32'h0);
      apb(1'b0, 8'h00, 32'h0);
      chk(rd, 32'h0);
      apb(1'b1, 8'h00, 32'h0000_ffff);
      apb(1'b0, 8'h00, 32'h0);
      chk(rd, 32'h0000_7777);
      apb(1'b0, 8'h40, 32'h0);
      chk({rd[30:0], err}, 32'h1);
      $display("test regs done");
   endtask : t_regs

   task automatic t_cmd();
      int code [8] = '{1, 2, 3, 4, 5, 0, 4, 1};
      int len [8] = '{70, 70, 70, 70, 70, 70, 70, 30};
      int i;
      for (int n = 0; n < 8; n++)
      begin
         i = n % 4;
         tod_internal <= (n != 6);
         hits <= '{default: 0};
         apb(1'b1, 8'h00, 32'(code[n]) << (4 * i));
         apb(1'b1, 8'h04, 32'h5a << (8 * i));
         acp_contacts_i.press(i, len[n] * MS);
         repeat (20) @(posedge clk);
         chk(hits.sum(), (n < 5) ? 1 : 0);
         if (n < 5)
            chk(hits[code[n] - 1], 1);
      end
      chk(32'(preset_sel), 32'h5a);
      $display("test commands done");
   endtask : t_cmd

   task automatic t_lvl();
      apb(1'b1, 8'h08, 32'h3c);
      lvl_evt <= 6'h20;
      repeat (4) @(posedge clk);
      chk(32'(alarm_n), 32'h6);
      lvl_evt <= 6'h00;
      repeat (4) @(posedge clk);
      chk(32'(alarm_n), 32'h7);
      apb(1'b1, 8'h18, 32'h5);
      apb(1'b1, 8'h08, 32'h6);
      lvl_evt <= 6'h04;
      repeat (3 * MS) @(posedge clk);
      chk(32'(alarm_n), 32'h7);
      lvl_evt <= 6'h00;
      repeat (2) @(posedge clk);
      lvl_evt <= 6'h04;
      repeat (3 * MS) @(posedge clk);
      chk(32'(alarm_n), 32'h7);
      repeat (3 * MS) @(posedge clk);
      chk(32'(alarm_n), 32'h6);
      lvl_evt <= 6'h02;
      repeat (4) @(posedge clk);
      chk(32'(alarm_n), 32'h6);
      apb(1'b0, 8'h2c, 32'h0);
      chk(rd, 32'h0008_02f0);
      lvl_evt <= 6'h00;
      repeat (4) @(posedge clk);
      $display("test levels done");
   endtask : t_lvl

   task automatic t_time();
      apb(1'b1, 8'h0c, 32'h40);
      apb(1'b1, 8'h28, 32'h000c_2205);
      prog_hours <= 5'h0c;
      prog_minutes <= 6'h23;
      prog_seconds <= 6'h05;
      repeat (3 * MS) @(posedge clk);
      chk(32'(alarm_n), 32'h7);
      prog_minutes <= 6'h22;
      repeat (2) @(posedge clk);
      prog_seconds <= 6'h06;
      repeat (1010 * MS) @(posedge clk);
      chk(low_len[1], 1000 * MS);
      $display("test alarm time done");
   endtask : t_time

   task automatic t_gm();
      apb(1'b1, 8'h10, 32'h180);
      grandmaster_role <= 2'h3;
      repeat (4) @(posedge clk);
      grandmaster_role <= 2'h2;
      repeat (25 * MS) @(posedge clk);
      chk(low_len[2], 20 * MS);
      grandmaster_role <= 2'h0;
      repeat (2 * MS) @(posedge clk);
      chk(32'(alarm_n), 32'h3);
      repeat (25 * MS) @(posedge clk);
      $display("test leader loss done");
   endtask : t_gm

   task automatic results();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : results

   initial
   begin
      repeat (5) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      t_regs();
      t_cmd();
      t_lvl();
      t_time();
      t_gm();
      results();
   end

   initial
   begin
      repeat (20000) @(posedge clk);
      errors++;
      results();
   end
endmodule : tb_acp_port
